// ---- inc/ubd_pkg.sv ----
package ubd_pkg;
    localparam int UBD_WIDTH = 18;
    localparam logic UBD_STORE_RST = 1'h0;
    localparam logic UBD_EN_OFF = 1'h0;
    localparam int UBD_BUF_DEPTH = 2;
endpackage

// ---- hdl/ubd_channel.sv ----
module ubd_channel
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic data_i,
    input wire logic data_driven_i,
    input wire logic transparency_control_i,
    input wire logic dclk_rise_i,
    output logic store_o
);
    import ubd_pkg::*;

    logic held_ff;
    logic nxt_held;
    logic store_ff;
    logic nxt_store;
    logic clean_data;

    always_comb
    begin
        // Bus hold on floating input
        clean_data = data_driven_i ? data_i : held_ff;
        nxt_held = clean_data;
        if (transparency_control_i)
        begin
            nxt_store = clean_data;
        end
        else if (dclk_rise_i)
        begin
            nxt_store = clean_data;
        end
        else
        begin
            nxt_store = store_ff;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            held_ff <= UBD_STORE_RST;
            store_ff <= UBD_STORE_RST;
        end
        else
        begin
            held_ff <= nxt_held;
            store_ff <= nxt_store;
        end
    end

    assign store_o = store_ff;

    hold_steady_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (!transparency_control_i && !dclk_rise_i) |=> $stable(store_ff))
        else $error("stored value moved without clock edge");
    capture_edge_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (!transparency_control_i && dclk_rise_i && data_driven_i) |=> (store_ff == $past(data_i)))
        else $error("rising edge did not capture input");
    pass_through_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (transparency_control_i && data_driven_i) |=> (store_ff == $past(data_i)))
        else $error("transparent mode did not follow input");
    bus_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (transparency_control_i && !data_driven_i) |=> (store_ff == $past(held_ff)))
        else $error("floating input changed stored value");
endmodule

// ---- hdl/ubd_top.sv ----
module ubd_top
#(
    parameter int WIDTH = ubd_pkg::UBD_WIDTH
)
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] data_i,
    input wire logic [WIDTH-1:0] data_driven_i,
    input wire logic data_valid_i,
    output logic data_ready_o,
    input wire logic transparency_control_i,
    input wire logic dclk_i,
    input wire logic out_en_n_i,
    output logic [WIDTH-1:0] y_o,
    output logic [WIDTH-1:0] y_oe_o,
    output logic y_valid_o,
    input wire logic y_ready_i
);
    import ubd_pkg::*;

    logic dclk_ff;
    logic nxt_dclk;
    logic dclk_rise;
    logic [WIDTH-1:0] store;
    logic [WIDTH-1:0] last_store_ff;
    logic [WIDTH-1:0] nxt_last_store;
    logic changed;

    // Two-entry output buffer
    logic [WIDTH-1:0] buf_ff [UBD_BUF_DEPTH];
    logic [WIDTH-1:0] nxt_buf [UBD_BUF_DEPTH];
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    logic [WIDTH-1:0] y_ff;
    logic [WIDTH-1:0] nxt_y;
    logic [WIDTH-1:0] oe_ff;
    logic [WIDTH-1:0] nxt_oe;
    logic yv_ff;
    logic nxt_yv;
    logic rdy_ff;
    logic nxt_rdy;
    logic push;
    logic pop;
    logic advance;
    logic take;

    assign dclk_rise = dclk_i && !dclk_ff;
    assign take = data_valid_i && rdy_ff;

    // Inputs reach the channels only while buffer has room
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_ch
            ubd_channel u_ch (
                .mclk_i(mclk_i),
                .reset_n_i(reset_n_i),
                .data_i(data_i[g]),
                .data_driven_i(data_driven_i[g] & take),
                .transparency_control_i(transparency_control_i & take),
                .dclk_rise_i(dclk_rise & take),
                .store_o(store[g])
            );
        end
    endgenerate

    // Data clock edge detect
    always_comb
    begin
        nxt_dclk = dclk_i;
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            dclk_ff <= 1'h0;
        end
        else
        begin
            dclk_ff <= nxt_dclk;
        end
    end

    // Two-entry buffer, head moves into output stage
    always_comb
    begin
        changed = (store != last_store_ff);
        push = changed && (cnt_ff < 2'(UBD_BUF_DEPTH));
        advance = !yv_ff || y_ready_i;
        pop = advance && (cnt_ff != 2'h0);
        nxt_buf = buf_ff;
        nxt_cnt = cnt_ff;
        if (pop)
        begin
            nxt_buf[0] = buf_ff[1];
            nxt_cnt = cnt_ff - 2'h1;
        end
        if (push)
        begin
            nxt_buf[nxt_cnt[0]] = store;
            nxt_cnt = nxt_cnt + 2'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            buf_ff[0] <= '0;
            buf_ff[1] <= '0;
            cnt_ff <= 2'h0;
        end
        else
        begin
            buf_ff <= nxt_buf;
            cnt_ff <= nxt_cnt;
        end
    end

    // Last word queued, so unchanged words are not queued again
    always_comb
    begin
        nxt_last_store = push ? store : last_store_ff;
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            last_store_ff <= '0;
        end
        else
        begin
            last_store_ff <= nxt_last_store;
        end
    end

    // Output stage holds its word until taken
    always_comb
    begin
        nxt_y = y_ff;
        nxt_yv = yv_ff;
        if (advance)
        begin
            nxt_yv = pop;
        end
        if (pop)
        begin
            nxt_y = buf_ff[0];
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            y_ff <= '0;
            yv_ff <= 1'h0;
        end
        else
        begin
            y_ff <= nxt_y;
            yv_ff <= nxt_yv;
        end
    end

    // Room flag for the source side
    always_comb
    begin
        nxt_rdy = (nxt_cnt < 2'(UBD_BUF_DEPTH));
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdy_ff <= 1'h0;
        end
        else
        begin
            rdy_ff <= nxt_rdy;
        end
    end

    // Enable gates drivers only
    always_comb
    begin
        nxt_oe = out_en_n_i ? {WIDTH{UBD_EN_OFF}} : {WIDTH{1'h1}};
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            oe_ff <= '0;
        end
        else
        begin
            oe_ff <= nxt_oe;
        end
    end

    assign y_o = y_ff;
    assign y_oe_o = oe_ff;
    assign y_valid_o = yv_ff;
    assign data_ready_o = rdy_ff;

    hiz_release_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        out_en_n_i |=> (y_oe_o == '0))
        else $error("outputs driven while disabled");
    drive_on_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !out_en_n_i |=> (y_oe_o == '1))
        else $error("outputs not driven while enabled");
    enable_keeps_store_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        ($changed(out_en_n_i) && !transparency_control_i && !dclk_rise) |=> $stable(store))
        else $error("enable change disturbed stored data");
    latch_on_fall_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        ($fell(transparency_control_i) && !dclk_rise) |=> $stable(store))
        else $error("latched value lost after transparency fell");
    buffer_bound_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        cnt_ff <= 2'(UBD_BUF_DEPTH))
        else $error("buffer overfilled");
    word_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (y_valid_o && !y_ready_i) |=> (y_valid_o && $stable(y_o)))
        else $error("output word changed before it was taken");
    full_refuse_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (cnt_ff == 2'(UBD_BUF_DEPTH)) |-> !data_ready_o)
        else $error("ready shown while buffer full");
endmodule

// ---- verif/ubd_sink.sv ----
module ubd_sink (
    input wire logic mclk_i,
    input wire logic stall_i,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Receiving bus, accepts at random or stalls on request
    initial ready_o = 1'h0;
    always @(posedge mclk_i)
        ready_o <= #1 !stall_i && ($urandom % 3 != 0);
endmodule

// ---- verif/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ubd_pkg::*;
    logic mclk_i = 1'h0, reset_n_i = 1'h0, v = 1'h0, tc = 1'h0, dk = 1'h0, oen = 1'h1, stall = 1'h0;
    logic [UBD_WIDTH-1:0] d = '0, dd = '1, y, oe, st = '0, hl = '0, s_d, s_dd;
    logic rdy, yv, yr, s_v = 1'h0, s_rdy = 1'h0, s_tc = 1'h0, s_dk = 1'h0, p_dk = 1'h0, p_oen = 1'h1;
    logic [UBD_WIDTH-1:0] q[$];
    int fails = 0, checked = 0, mode;
    always #25 mclk_i = ~mclk_i;
    ubd_top ubd_top_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .data_i(d), .data_driven_i(dd),
        .data_valid_i(v), .data_ready_o(rdy), .transparency_control_i(tc), .dclk_i(dk),
        .out_en_n_i(oen), .y_o(y), .y_oe_o(oe), .y_valid_o(yv), .y_ready_i(yr));
    ubd_sink ubd_sink_i (.mclk_i(mclk_i), .stall_i(stall), .ready_o(yr));
    task chk(input string n, input logic [UBD_WIDTH-1:0] seen, input logic [UBD_WIDTH-1:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task summarize;
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Stored value after a capture, floating bits keep their level
    function logic [UBD_WIDTH-1:0] next_word(input logic [UBD_WIDTH-1:0] s, a, drv);
        return (a & drv) | (s & ~drv);
    endfunction
    always @(negedge mclk_i)
    begin
        if (reset_n_i)
        begin
            chk("y_oe", oe, {UBD_WIDTH{~p_oen}});
            if (yv === 1'h1 && yr === 1'h1)
                chk("y_word", y, q.size() ? q.pop_front() : ~y);
        end
        p_oen = oen;
        s_d = d;
        s_dd = dd;
        s_v = v;
        s_rdy = rdy;
        s_tc = tc;
        s_dk = dk;
    end
    always @(posedge mclk_i)
    begin
        if (reset_n_i && s_v === 1'h1 && s_rdy === 1'h1)
        begin
            hl = next_word(hl, s_d, s_dd);
            if (s_tc || (s_dk && !p_dk))
            begin
                if (hl !== st)
                    q.push_back(hl);
                st = hl;
            end
        end
        p_dk = reset_n_i ? s_dk : 1'h0;
    end
    initial
    begin
        void'($urandom(5676));
        repeat (2) @(posedge mclk_i);
        #1 reset_n_i = 1'h1;
        @(posedge mclk_i);
        // Free mix, steady clock, floating inputs, stalled receiver
        for (mode = 0; mode < 4; mode++)
            repeat (600)
            begin
                @(posedge mclk_i);
                #1;
                v = $urandom % 4 != 0;
                d = UBD_WIDTH'($urandom);
                dd = mode == 2 ? '0 : ($urandom % 8 == 0 ? UBD_WIDTH'($urandom) : '1);
                tc = mode != 1 && $urandom % 4 == 0;
                dk = mode == 1 ? 1'h1 : 1'($urandom);
                oen = $urandom % 8 == 0;
                stall = mode == 3;
            end
        @(posedge mclk_i);
        #1;
        v = 1'h0;
        stall = 1'h0;
        repeat (60) @(posedge mclk_i);
        chk("drained", UBD_WIDTH'(q.size()), '0);
        summarize;
    end
    initial
    begin
        #300000;
        fails++;
        summarize;
    end
endmodule
